// *** design/gsp_protect_top.sv ***
// Global protect and unprotect decoder for the first status byte
// Operation
// - All-ones bits 5..2 protect every sector
// - All-zeros bits 5..2 unprotect every sector
// - Other patterns leave sectors; bits 6,1,0 ignored
// - Protect during suspend aborts, clears write enable
// - Only bit 7 stored, as lock bit
// - Read bits 5..2 show pin and protection
// - Pin low and lock set: ignore everything
// - Pin high and lock set: load lock only
// - Lock clear: load lock with global decode
// - 0Fh clears lock only with pin high
// - F0h sets lock, sectors unchanged
// - Power-up leaves all sectors protected
// - Hardware lock needs pin low, lock set
`timescale 1ns/10ps
module gsp_protect_top (
  // Clock and reset
  input  wire logic                         clk_sys,
  input  wire logic                         srst,
  // Serial pins
  input  wire logic                         cs_n,
  input  wire logic                         sck,
  input  wire logic                         si,
  output logic                              so_out,
  output logic                              so_oe_n,
  // Write-protect pin, asserted low
  input  wire logic                         wp_n,
  // Suspend state from the program and erase logic
  input  wire logic                         suspend_active,
  // Protection state toward the array and sector commands
  output logic [gsp_pkg::NUM_SECTORS-1:0]   sector_prot,
  output logic                              protection_regs_lock,
  output logic                              write_enable_latch,
  output logic                              hw_lock_active
);
  import gsp_pkg::*;

  // Command decode states
  typedef enum logic [2:0] {
    GSP_ST_OPCODE,    // Waiting for the opcode byte
    GSP_ST_WREN,      // Write enable opcode complete
    GSP_ST_WRDI,      // Write disable opcode complete
    GSP_ST_WSR_DATA,  // Status write opcode seen, data pending
    GSP_ST_WSR_FULL,  // Status write data byte captured
    GSP_ST_RDSR,      // Streaming the status byte
    GSP_ST_SKIP       // Unknown opcode, rest of frame ignored
  } gsp_state_t;

  gsp_state_t  state;          // Current decode state
  gsp_state_t  next_state;     // Decode state after this cycle
  logic [7:0]  rx_byte;        // Byte from the serial engine
  logic        rx_valid;       // Byte strobe
  logic        byte_aligned;   // Frame sits on a byte boundary
  logic        frame_end;      // Chip select just went high
  logic        frame_ok;       // Frame ended on a byte boundary
  logic [7:0]  wr_data;        // Captured status write data
  logic [3:0]  glob_field;     // Written bits 5 to 2
  logic        wsr_commit;     // Complete, enabled status write
  logic        prot_req;       // Global protect requested and permitted
  logic        unprot_req;     // Global unprotect requested and permitted
  logic        glob_abort;     // Global protect blocked by suspend
  logic [1:0]  swp;            // Protection summary for read-back
  logic [7:0]  status_byte;    // First status byte as read

  // Serial byte engine
  gsp_spi_shift u_shift (
    .clk_sys      (clk_sys),
    .srst         (srst),
    .cs_n         (cs_n),
    .sck          (sck),
    .si           (si),
    .so_out       (so_out),
    .so_oe_n      (so_oe_n),
    .tx_byte      (status_byte),
    .tx_en        (state == GSP_ST_RDSR),
    .rx_byte      (rx_byte),
    .rx_valid     (rx_valid),
    .byte_aligned (byte_aligned),
    .frame_end    (frame_end)
  );

  // Lock qualifiers
  assign hw_lock_active = ~wp_n & protection_regs_lock;
  assign frame_ok       = frame_end & byte_aligned;
  assign glob_field     = wr_data[SB_GLOB_HI:SB_GLOB_LO];

  // Status write takes effect only when complete and enabled
  assign wsr_commit = frame_ok & (state == GSP_ST_WSR_FULL) & write_enable_latch;

  // Global decode runs only while the lock bit is clear
  assign prot_req   = wsr_commit & ~protection_regs_lock & (glob_field == GLOB_PROTECT);
  assign unprot_req = wsr_commit & ~protection_regs_lock & (glob_field == GLOB_UNPROTECT);
  assign glob_abort = prot_req & suspend_active;

  // Protection summary: none, some or all sectors protected
  always_comb begin
    if (&sector_prot) begin
      swp = SWP_ALL;
    end else if (|sector_prot) begin
      swp = SWP_SOME;
    end else begin
      swp = SWP_NONE;
    end
  end

  // Read-back byte: bits 5 to 2 show live state, never written data
  always_comb begin
    status_byte                       = '0;
    status_byte[SB_LOCK]              = protection_regs_lock;
    status_byte[SB_WP_LEVEL]          = wp_n;
    status_byte[SB_SWP_HI:SB_SWP_LO]  = swp;
    status_byte[SB_WEL]               = write_enable_latch;
  end

  // Next decode state
  always_comb begin
    next_state = state;
    if (frame_end) begin
      next_state = GSP_ST_OPCODE;
    end else if (rx_valid) begin
      unique case (state)
        GSP_ST_OPCODE: begin
          // Opcode selects the frame type
          unique case (rx_byte)
            OP_WRITE_ENABLE:  next_state = GSP_ST_WREN;
            OP_WRITE_DISABLE: next_state = GSP_ST_WRDI;
            OP_WRITE_STATUS1: next_state = GSP_ST_WSR_DATA;
            OP_READ_STATUS:   next_state = GSP_ST_RDSR;
            default:          next_state = GSP_ST_SKIP;
          endcase
        end
        GSP_ST_WSR_DATA: begin
          // First data byte is the one decoded
          next_state = GSP_ST_WSR_FULL;
        end
        GSP_ST_WREN, GSP_ST_WRDI, GSP_ST_WSR_FULL, GSP_ST_RDSR, GSP_ST_SKIP: begin
          // Extra bytes are ignored
          next_state = state;
        end
      endcase
    end
  end

  // Decode state register
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state <= GSP_ST_OPCODE;
    end else begin
      state <= next_state;
    end
  end

  // Status write data capture
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      wr_data <= '0;
    end else if (rx_valid && state == GSP_ST_WSR_DATA) begin
      wr_data <= rx_byte;
    end
  end

  // Sector protection bits, all protected from power-up
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      sector_prot <= {NUM_SECTORS{SECTOR_PROT_RST}};
    end else if (prot_req && !glob_abort) begin
      // Set every sector at once
      sector_prot <= '1;
    end else if (unprot_req) begin
      // Clear every sector at once
      sector_prot <= '0;
    end
    // Other patterns, locked states and aborts hold the bits
  end

  // Lock bit: only written bit 7 is stored
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      protection_regs_lock <= LOCK_RST;
    end else if (wsr_commit && !hw_lock_active && !glob_abort) begin
      // Soft lock or clear lock: bit 7 loads, hardware lock holds it
      protection_regs_lock <= wr_data[SB_LOCK];
    end
  end

  // Write enable latch
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      write_enable_latch <= WEL_RST;
    end else if (frame_ok && state == GSP_ST_WREN) begin
      write_enable_latch <= 1'b1;
    end else if (frame_ok && state == GSP_ST_WRDI) begin
      write_enable_latch <= 1'b0;
    end else if (frame_end && (state == GSP_ST_WSR_DATA || state == GSP_ST_WSR_FULL)) begin
      // Any status write, done, ignored or aborted, drops the latch
      write_enable_latch <= 1'b0;
    end
  end

  // Checks on the decoder
  default clocking gsp_cb @(posedge clk_sys);
  endclocking
  default disable iff (srst);

  AST_GLOBAL_PROTECT:
    assert property (wsr_commit && !protection_regs_lock && glob_field == 4'hf && !suspend_active
                     |=> sector_prot == '1)
    else $error("global protect did not set all sectors");

  AST_GLOBAL_UNPROTECT:
    assert property (wsr_commit && !protection_regs_lock && glob_field == 4'h0
                     |=> sector_prot == '0 && !protection_regs_lock == !wr_data[7])
    else $error("global unprotect did not clear all sectors");

  AST_OTHER_PATTERN:
    assert property (wsr_commit && glob_field != 4'hf && glob_field != 4'h0 |=> $stable(sector_prot))
    else $error("non-global pattern changed sectors");

  AST_SUSPEND_ABORT:
    assert property (wsr_commit && !protection_regs_lock && glob_field == 4'hf && suspend_active
                     |=> $stable(sector_prot) && $stable(protection_regs_lock) && !write_enable_latch)
    else $error("protect during suspend was not aborted");

  AST_READBACK:
    assert property (unprot_req |=> status_byte[SB_GLOB_HI:SB_GLOB_LO] == {1'b0, wp_n, SWP_NONE})
    else $error("status read-back does not show sector state");

  AST_HW_LOCK_HOLD:
    assert property (wsr_commit && !wp_n && protection_regs_lock
                     |=> protection_regs_lock && $stable(sector_prot))
    else $error("hardware lock did not hold");

  AST_SOFT_LOCK_LOAD:
    assert property (wsr_commit && wp_n && protection_regs_lock
                     |=> protection_regs_lock == wr_data[7] && $stable(sector_prot))
    else $error("soft lock did not load bit 7 only");

  AST_UNLOCKED_LOAD:
    assert property (wsr_commit && !protection_regs_lock && !(glob_field == 4'hf && suspend_active)
                     |=> protection_regs_lock == wr_data[7])
    else $error("lock bit not loaded from bit 7");

  AST_ABORTED_FRAME:
    assert property (frame_end && !byte_aligned
                     |=> $stable(sector_prot) && $stable(protection_regs_lock))
    else $error("misaligned frame changed protection");

  AST_NEEDS_WEL:
    assert property (frame_end && state == GSP_ST_WSR_FULL && !write_enable_latch
                     |=> $stable(sector_prot) && $stable(protection_regs_lock))
    else $error("status write acted without write enable");

  // Main scenarios
  COV_PROTECT:   cover property (prot_req && !glob_abort ##1 sector_prot == '1);
  COV_UNPROTECT: cover property (unprot_req ##1 sector_prot == '0);
  COV_SOFT_CLR:  cover property (wsr_commit && wp_n && protection_regs_lock && !wr_data[7]);
  COV_READ:      cover property (state == GSP_ST_RDSR && !so_oe_n);

endmodule : gsp_protect_top

// *** design/gsp_spi_shift.sv ***
// Serial byte engine: samples the pins and frames bytes on the system clock
`timescale 1ns/10ps
module gsp_spi_shift (
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       srst,
  // Serial pins
  input  wire logic       cs_n,
  input  wire logic       sck,
  input  wire logic       si,
  output logic            so_out,
  output logic            so_oe_n,
  // Byte side
  input  wire logic [7:0] tx_byte,
  input  wire logic       tx_en,
  output logic [7:0]      rx_byte,
  output logic            rx_valid,
  output logic            byte_aligned,
  output logic            frame_end
);
  import gsp_pkg::*;

  logic                 sck_q;    // Previous serial clock level
  logic                 cs_q;     // Previous chip select level
  logic [BIT_CNT_W-1:0] bit_cnt;  // Bits received in the current byte
  logic [6:0]           shift;    // Partial received byte
  logic                 sck_rise; // Rising serial clock inside a frame
  logic                 sck_fall; // Falling serial clock inside a frame

  // Edge detection on the pins, which are synchronous to clk_sys
  assign sck_rise     = sck & ~sck_q & ~cs_n;
  assign sck_fall     = ~sck & sck_q & ~cs_n;
  assign frame_end    = cs_n & ~cs_q;
  assign byte_aligned = (bit_cnt == '0);

  // Pin history
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      sck_q <= 1'b0;
      cs_q  <= 1'b1;
    end else begin
      sck_q <= sck;
      cs_q  <= cs_n;
    end
  end

  // Bit counter, cleared while deselected
  always_ff @(posedge clk_sys) begin
    if (srst || cs_n) begin
      bit_cnt <= '0;
    end else if (sck_rise) begin
      bit_cnt <= bit_cnt + 1'b1;
    end
  end

  // Input shifter and byte strobe
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      shift    <= '0;
      rx_byte  <= '0;
      rx_valid <= 1'b0;
    end else begin
      rx_valid <= 1'b0;
      if (sck_rise) begin
        shift <= {shift[5:0], si};
        // Eighth bit completes a byte
        if (bit_cnt == '1) begin
          rx_byte  <= {shift, si};
          rx_valid <= 1'b1;
        end
      end
    end
  end

  // Output shifter, driven on falling edges, released when deselected
  always_ff @(posedge clk_sys) begin
    if (srst || cs_n) begin
      so_out  <= 1'b0;
      so_oe_n <= 1'b1;
    end else if (sck_fall) begin
      so_out  <= tx_byte[~bit_cnt];
      so_oe_n <= ~tx_en;
    end
  end

endmodule : gsp_spi_shift

// *** shared/gsp_pkg.sv ***
// Shared constants for the global sector protect decoder
package gsp_pkg;

  // Sector array size
  localparam int unsigned NUM_SECTORS = 128;

  // Serial opcodes that this block decodes
  localparam logic [7:0] OP_WRITE_ENABLE  = 8'h06;  // Set write enable latch
  localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;  // Clear write enable latch
  localparam logic [7:0] OP_WRITE_STATUS1 = 8'h01;  // Write first status byte
  localparam logic [7:0] OP_READ_STATUS   = 8'h05;  // Read first status byte

  // Field positions inside the first status byte
  localparam int unsigned SB_LOCK      = 7;  // Protection registers lock
  localparam int unsigned SB_RSVD      = 6;  // Reserved, reads zero
  localparam int unsigned SB_PGM_ERR   = 5;  // Program or erase error, not modelled
  localparam int unsigned SB_WP_LEVEL  = 4;  // Write-protect pin level
  localparam int unsigned SB_SWP_HI    = 3;  // Software protection summary, high
  localparam int unsigned SB_SWP_LO    = 2;  // Software protection summary, low
  localparam int unsigned SB_WEL       = 1;  // Write enable latch
  localparam int unsigned SB_BUSY      = 0;  // Busy, always idle here
  localparam int unsigned SB_GLOB_HI   = 5;  // Global decode field, high
  localparam int unsigned SB_GLOB_LO   = 2;  // Global decode field, low

  // Global decode patterns in written bits 5 to 2
  localparam logic [3:0] GLOB_PROTECT   = 4'hf;
  localparam logic [3:0] GLOB_UNPROTECT = 4'h0;

  // Software protection summary codes
  localparam logic [1:0] SWP_NONE = 2'h0;
  localparam logic [1:0] SWP_SOME = 2'h1;
  localparam logic [1:0] SWP_ALL  = 2'h3;

  // Reset values
  localparam logic SECTOR_PROT_RST = 1'b1;  // All sectors protected at power-up
  localparam logic LOCK_RST        = 1'b0;
  localparam logic WEL_RST         = 1'b0;

  // Serial bit counter width
  localparam int unsigned BIT_CNT_W = 3;

endpackage : gsp_pkg

// *** verif/gsp_host_model.sv ***
// Serial host model that frames command and status traffic
`timescale 1ns/10ps
module gsp_host_model (
  // Clock
  input  wire logic clk_sys,
  // Serial pins toward the device
  output logic      cs_n,
  output logic      sck,
  output logic      si,
  input  wire logic so_out,
  input  wire logic so_oe_n
);
  import gsp_pkg::*;
  logic [7:0] rd_byte;  // Last eight bits seen on so
  // Idle: deselected, clock parked low
  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    si = 1'b0;
    rd_byte = 8'h00;
  end
  // Waits n clocks and steps just past the edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : tick
  // Sends nbits MSB first, two clocks per phase; so reads high when released
  task automatic frame(input logic [23:0] data, input int nbits);
    cs_n = 1'b0;
    for (int i = 0; i < nbits; i++) begin
      si = data[nbits-1-i];
      tick(2);
      rd_byte = {rd_byte[6:0], so_oe_n ? 1'b1 : so_out};
      sck = 1'b1;
      tick(2);
      sck = 1'b0;
    end
    tick(1);  // Three clocks from last rise to deselect
    cs_n = 1'b1;
    si = ~si;  // Released line stops showing the last bit
    tick(2);  // Deselect time before the next frame
  endtask : frame
  // Write enable frame ahead of every status write
  task automatic status_write(input logic [7:0] d);
    frame({16'h0000, OP_WRITE_ENABLE}, 8);
    frame({8'h00, OP_WRITE_STATUS1, d}, 16);
  endtask : status_write
  // Reads the first status byte
  task automatic read_status(output logic [7:0] v);
    frame({8'h00, OP_READ_STATUS, 8'h00}, 16);
    v = rd_byte;
  endtask : read_status
endmodule : gsp_host_model

// *** verif/gsp_protect_top_tb.sv ***
// Self-checking bench for the global protect decoder
`timescale 1ns/10ps
module gsp_protect_top_tb;
  import gsp_pkg::*;
  // Pin level, suspend, written byte, expected protect and lock
  typedef struct packed {
    logic       wp;
    logic       susp;
    logic [7:0] data;
    logic       prot;
    logic       lock;
  } gsp_row_t;
  logic                   clk_sys, srst, cs_n, sck, si, so_out, so_oe_n;
  logic                   wp_n, suspend_active, protection_regs_lock;
  logic                   write_enable_latch, hw_lock_active;
  logic [NUM_SECTORS-1:0] sector_prot;
  logic [7:0]             st;  // Status byte read back
  int                     num_errors, check_count, cycles;
  gsp_row_t               rows [16];
  // Device under test
  gsp_protect_top uut (.clk_sys(clk_sys), .srst(srst), .cs_n(cs_n), .sck(sck), .si(si),
    .so_out(so_out), .so_oe_n(so_oe_n), .wp_n(wp_n), .suspend_active(suspend_active),
    .sector_prot(sector_prot), .protection_regs_lock(protection_regs_lock),
    .write_enable_latch(write_enable_latch), .hw_lock_active(hw_lock_active));
  // Serial host
  gsp_host_model host (.clk_sys(clk_sys), .cs_n(cs_n), .sck(sck), .si(si),
    .so_out(so_out), .so_oe_n(so_oe_n));
  // 250 MHz clock
  always #2 clk_sys = ~clk_sys;
  // Hang guard
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      wrap_up();
    end
  end
  // Compares one value
  task automatic chk(input string what, input logic [127:0] seen, input logic [127:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  // Compares the protection state outputs
  task automatic chk_state(input logic prot, input logic lock);
    chk("sector_prot", sector_prot, {NUM_SECTORS{prot}});
    chk("lock", protection_regs_lock, lock);
    chk("wel", write_enable_latch, 1'b0);
    chk("hw_lock", hw_lock_active, ~wp_n & lock);
  endtask : chk_state
  // Counts and verdict
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : wrap_up
  // Main sequence
  initial begin
    clk_sys = 1'b0;
    srst = 1'b1;
    wp_n = 1'b1;
    suspend_active = 1'b0;
    num_errors = 0;
    check_count = 0;
    cycles = 0;
    rows[0] = '{1'b1, 1'b0, 8'h00, 1'b0, 1'b0};
    rows[1] = '{1'b1, 1'b0, 8'h7f, 1'b1, 1'b0};
    rows[2] = '{1'b1, 1'b0, 8'h43, 1'b0, 1'b0};
    rows[3] = '{1'b1, 1'b1, 8'h7f, 1'b0, 1'b0};
    rows[4] = '{1'b1, 1'b0, 8'h2c, 1'b0, 1'b0};
    rows[5] = '{1'b1, 1'b0, 8'hbc, 1'b1, 1'b1};
    rows[6] = '{1'b1, 1'b0, 8'h00, 1'b1, 1'b0};
    rows[7] = '{1'b1, 1'b0, 8'hf0, 1'b1, 1'b1};
    rows[8] = '{1'b1, 1'b0, 8'h0f, 1'b1, 1'b0};
    rows[9] = '{1'b1, 1'b0, 8'h00, 1'b0, 1'b0};
    rows[10] = '{1'b0, 1'b0, 8'hff, 1'b1, 1'b1};
    rows[11] = '{1'b0, 1'b0, 8'h03, 1'b1, 1'b1};
    rows[12] = '{1'b0, 1'b0, 8'h0f, 1'b1, 1'b1};
    rows[13] = '{1'b1, 1'b0, 8'h03, 1'b1, 1'b0};
    rows[14] = '{1'b1, 1'b0, 8'h00, 1'b0, 1'b0};
    rows[15] = '{1'b1, 1'b0, 8'hf0, 1'b0, 1'b1};
    repeat (3) @(posedge clk_sys);
    #1 srst = 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
    chk_state(1'b1, 1'b0);
    $display("reset defaults done");
    // Table of status writes, each followed by a status read
    foreach (rows[i]) begin
      wp_n = rows[i].wp;
      suspend_active = rows[i].susp;
      host.status_write(rows[i].data);
      chk_state(rows[i].prot, rows[i].lock);
      host.read_status(st);
      chk("status", st, {rows[i].lock, 2'b00, rows[i].wp, {2{rows[i].prot}}, 2'b00});
      $display("row %0d done", i);
    end
    // Status write without write enable is dropped
    host.frame({8'h00, OP_WRITE_STATUS1, 8'hff}, 16);
    chk_state(1'b0, 1'b1);
    // Write enable sets the latch and shows in status, disable clears it
    host.frame({16'h0000, OP_WRITE_ENABLE}, 8);
    chk("wel_set", write_enable_latch, 1'b1);
    host.read_status(st);
    chk("status_wel", st[SB_WEL], 1'b1);
    host.frame({16'h0000, OP_WRITE_DISABLE}, 8);
    chk("wel_clr", write_enable_latch, 1'b0);
    $display("write enable test done");
    // Frame cut mid-byte after the opcode leaves protection unchanged but drops write enable
    host.frame({16'h0000, OP_WRITE_ENABLE}, 8);
    host.frame({8'h00, 4'h0, OP_WRITE_STATUS1, 4'h0}, 12);
    chk_state(1'b0, 1'b1);
    // Frame cut after a full data byte must not clear the soft lock
    host.frame({16'h0000, OP_WRITE_ENABLE}, 8);
    host.frame({4'h0, OP_WRITE_STATUS1, 8'h00, 4'h0}, 20);
    chk_state(1'b0, 1'b1);
    $display("misaligned frame test done");
    // Reset in mid-run restores protected sectors
    srst = 1'b1;
    repeat (2) @(posedge clk_sys);
    #1 srst = 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
    chk_state(1'b1, 1'b0);
    $display("mid-run reset done");
    wrap_up();
  end
endmodule : gsp_protect_top_tb
